// ---- include/dtc_consts.svh ----
// register indices, field positions, reset values and cycle counts of the timer unit
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// register indices; byte address is four times the index
`define DTC_IDX_CTRL   8'h88
`define DTC_IDX_MODE   8'h89
`define DTC_IDX_TL_A   8'h8A
`define DTC_IDX_TL_B   8'h8B
`define DTC_IDX_TH_A   8'h8C
`define DTC_IDX_TH_B   8'h8D
`define DTC_IDX_CFG    8'h8E
`define DTC_IDX_SVC    8'h8F
// control/flag register bit positions
`define DTC_TF_B       7
`define DTC_TR_B       6
`define DTC_TF_A       5
`define DTC_TR_A       4
`define DTC_IE_B       3
`define DTC_IT_B       2
`define DTC_IE_A       1
`define DTC_IT_A       0
// mode register: timer a in [3:0], timer b in [7:4]
`define DTC_MODE_B_LSB 4
// service register bits (write one to acknowledge)
`define DTC_SVC_TF_A   0
`define DTC_SVC_TF_B   1
`define DTC_SVC_IE_A   2
`define DTC_SVC_IE_B   3
// reset values
`define DTC_RST_BYTE   8'h00
// oscillator periods per machine cycle
`define DTC_OSC_PER_MC    4'hC
`define DTC_OSC_PER_MC_SIX 4'h6
// low byte mask that keeps the 13-bit mode's upper bits at zero
`define DTC_MASK_13    8'h1F
`endif

// ---- include/dtc_pkg.sv ----
// types shared by the timer unit and its bus slave
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'h0,
    DTC_MODE_16 = 2'h1,
    DTC_MODE_8R = 2'h2,
    DTC_MODE_SP = 2'h3
  } dtc_mode_type;
  // one timer's nibble of the mode register
  typedef struct packed {
    logic         gate;
    logic         ct;
    dtc_mode_type mode;
  } dtc_tcfg_type;
  // register write strobe from the bus slave
  typedef struct packed {
    logic       en;
    logic [7:0] idx;
    logic [7:0] data;
  } dtc_wr_type;
endpackage

// ---- src/dtc_axil_slave.sv ----
// AXI4-Lite slave front end turning bus accesses into register strobes
`timescale 1ns/1ps
module dtc_axil_slave #(
  parameter int ADDR_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output wire logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  output      dtc_pkg::dtc_wr_type wr,
  input  wire logic              wr_hit,
  output wire logic [7:0]        rd_idx,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_hit
);
  logic       aw_full;
  logic [7:0] aw_idx;
  logic       w_full;
  logic [7:0] w_data;
  logic       w_lane0;
  logic       do_wr;

  // each channel holds one item until both are present
  assign awready = !aw_full;
  assign wready  = !w_full;
  assign arready = !rvalid;
  assign rd_idx  = araddr[9:2];
  assign do_wr   = aw_full && w_full && !bvalid;
  always_comb begin
    wr = {do_wr && w_lane0, aw_idx, w_data};
  end

  // write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_idx  <= 8'h00;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_idx  <= awaddr[9:2];
    end else if (do_wr) begin
      aw_full <= 1'b0;
    end
  end

  // write data holding; only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full  <= 1'b0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_full  <= 1'b1;
      w_data  <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (do_wr) begin
      w_full  <= 1'b0;
    end
  end

  // write response; unmapped index answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? 2'h0 : 2'h2;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data captured in the address handshake cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_data};
      rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // dtc_axil_slave

// ---- src/dtc_timer_unit.sv ----
// two 16-bit timer/counters with four modes and external interrupt flags
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_timer_unit #(
  parameter int ADDR_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              count_input_a,
  input  wire logic              count_input_b,
  input  wire logic              ext_irq_a_pin,
  input  wire logic              ext_irq_b_pin,
  output      logic              timer_a_overflow_flag,
  output      logic              timer_b_overflow_flag,
  output      logic              ext_irq_a_edge_flag,
  output      logic              ext_irq_b_edge_flag
);
  dtc_pkg::dtc_wr_type  wr;
  dtc_pkg::dtc_tcfg_type cfg_a;
  dtc_pkg::dtc_tcfg_type cfg_b;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_idx;
  logic [7:0]  rd_data;
  logic [3:0]  pin_s1;
  logic [3:0]  pin_s2;
  logic [1:0]  irq_prev;
  logic [1:0]  irq_fall;
  logic [1:0]  cnt_now;
  logic [1:0]  cnt_prev;
  logic [1:0]  cnt_fall;
  logic [3:0]  presc;
  logic [3:0]  mc_len;
  logic        mc_tick;
  logic        six_clock_cycle_mode;
  logic [7:0]  timer_mode_select;
  logic        timer_a_run;
  logic        timer_b_run;
  logic        ext_irq_a_trigger_type;
  logic        ext_irq_b_trigger_type;
  logic [7:0]  timer_a_count_low;
  logic [7:0]  timer_a_count_high;
  logic [7:0]  timer_b_count_low;
  logic [7:0]  timer_b_count_high;
  logic        inc_a;
  logic        inc_b;
  logic        inc_h;
  logic        split_a;
  logic [16:0] next_a;
  logic [16:0] next_b;
  logic [7:0]  next_th_a;
  logic        hw_tf_a;
  logic        hw_tf_b;
  logic        hw_ie_a;
  logic        hw_ie_b;
  logic        wr_ctrl;
  logic [3:0]  mc_since;
  logic        mc_mode_held;
  logic        wr_svc;
  logic [7:0]  tl_a_mask;
  logic [7:0]  tl_b_mask;

  // bus front end
  dtc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr      (wr),
    .wr_hit  (wr_hit),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  // mode register split into per-timer fields
  assign cfg_a = timer_mode_select[3:0];
  assign cfg_b = timer_mode_select[7:4];
  assign split_a = cfg_a.mode == dtc_pkg::DTC_MODE_SP;
  assign wr_ctrl = wr.en && (wr.idx == `DTC_IDX_CTRL);
  assign wr_svc  = wr.en && (wr.idx == `DTC_IDX_SVC);
  assign wr_hit  = (wr.idx >= `DTC_IDX_CTRL) && (wr.idx <= `DTC_IDX_SVC);
  assign rd_hit  = (rd_idx >= `DTC_IDX_CTRL) && (rd_idx <= `DTC_IDX_SVC);

  // two-stage synchronisers for count and interrupt pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 4'hF;
      pin_s2 <= 4'hF;
    end else begin
      pin_s1 <= {ext_irq_b_pin, ext_irq_a_pin, count_input_b, count_input_a};
      pin_s2 <= pin_s1;
    end
  end

  // machine cycle prescaler, twelve or six clocks
  assign mc_len  = six_clock_cycle_mode ? `DTC_OSC_PER_MC_SIX : `DTC_OSC_PER_MC;
  assign mc_tick = presc >= (mc_len - 4'h1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc <= 4'h0;
    end else begin
      presc <= mc_tick ? 4'h0 : presc + 4'h1;
    end
  end

  // count inputs sampled once per machine cycle; edge seen over two samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_now  <= 2'h3;
      cnt_prev <= 2'h3;
    end else if (mc_tick) begin
      cnt_now  <= pin_s2[1:0];
      cnt_prev <= cnt_now;
    end
  end
  assign cnt_fall = {2{mc_tick}} & cnt_prev & ~cnt_now;

  // interrupt pin falling edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_prev <= 2'h3;
    end else begin
      irq_prev <= pin_s2[3:2];
    end
  end
  assign irq_fall = irq_prev & ~pin_s2[3:2];

  // count enables: run, gate and timer/counter select
  assign inc_a = timer_a_run && (!cfg_a.gate || pin_s2[2])
                 && (cfg_a.ct ? cnt_fall[0] : mc_tick);
  assign inc_b = timer_b_run && (!cfg_b.gate || pin_s2[3])
                 && (cfg_b.mode != dtc_pkg::DTC_MODE_SP)
                 && (cfg_b.ct ? cnt_fall[1] : mc_tick);
  assign inc_h = split_a && timer_b_run && mc_tick;

  // one count step for a timer: returns {overflow, high, low}
  function automatic logic [16:0] step(
    input dtc_pkg::dtc_mode_type mode,
    input logic [7:0]            th,
    input logic [7:0]            tl,
    input logic                  inc
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13  = {1'b0, th, tl[4:0]} + 14'h0001;
    s16  = {1'b0, th, tl} + 17'h00001;
    s8   = {1'b0, tl} + 9'h001;
    step = {1'b0, th, tl};
    if (inc) begin
      case (mode)
        dtc_pkg::DTC_MODE_13: step = {s13[13], s13[12:5], 3'h0, s13[4:0]};
        dtc_pkg::DTC_MODE_16: step = s16;
        dtc_pkg::DTC_MODE_8R: step = s8[8] ? {1'b1, th, th} : {1'b0, th, s8[7:0]};
        default:              step = {s8[8], th, s8[7:0]};
      endcase
    end
  endfunction

  // next counts and hardware overflow and interrupt pin events
  assign next_a    = step(cfg_a.mode, timer_a_count_high, timer_a_count_low, inc_a);
  assign next_b    = step(cfg_b.mode, timer_b_count_high, timer_b_count_low, inc_b);
  assign next_th_a = !split_a ? next_a[15:8]
                   : timer_a_count_high + {7'h00, inc_h};
  assign hw_tf_a   = next_a[16];
  assign hw_tf_b   = split_a ? (inc_h && (&timer_a_count_high)) : next_b[16];
  assign hw_ie_a   = ext_irq_a_trigger_type ? irq_fall[0] : !pin_s2[2];
  assign hw_ie_b   = ext_irq_b_trigger_type ? irq_fall[1] : !pin_s2[3];

  // a write to a 13-bit low byte keeps the upper three bits clear
  assign tl_a_mask = (cfg_a.mode == dtc_pkg::DTC_MODE_13) ? `DTC_MASK_13 : 8'hFF;
  assign tl_b_mask = (cfg_b.mode == dtc_pkg::DTC_MODE_13) ? `DTC_MASK_13 : 8'hFF;

  // count registers: software writes override the step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_a_count_low  <= `DTC_RST_BYTE;
      timer_a_count_high <= `DTC_RST_BYTE;
      timer_b_count_low  <= `DTC_RST_BYTE;
      timer_b_count_high <= `DTC_RST_BYTE;
    end else begin
      timer_a_count_low  <= (wr.en && wr.idx == `DTC_IDX_TL_A)
                            ? (wr.data & tl_a_mask) : next_a[7:0];
      timer_a_count_high <= (wr.en && wr.idx == `DTC_IDX_TH_A) ? wr.data : next_th_a;
      timer_b_count_low  <= (wr.en && wr.idx == `DTC_IDX_TL_B)
                            ? (wr.data & tl_b_mask) : next_b[7:0];
      timer_b_count_high <= (wr.en && wr.idx == `DTC_IDX_TH_B) ? wr.data : next_b[15:8];
    end
  end

  // software-only control: mode, run, trigger types, cycle mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_select      <= `DTC_RST_BYTE;
      timer_a_run            <= 1'b0;
      timer_b_run            <= 1'b0;
      ext_irq_a_trigger_type <= 1'b0;
      ext_irq_b_trigger_type <= 1'b0;
      six_clock_cycle_mode   <= 1'b0;
    end else begin
      if (wr.en && wr.idx == `DTC_IDX_MODE) begin
        timer_mode_select <= wr.data;
      end
      if (wr_ctrl) begin
        timer_a_run            <= wr.data[`DTC_TR_A];
        timer_b_run            <= wr.data[`DTC_TR_B];
        ext_irq_a_trigger_type <= wr.data[`DTC_IT_A];
        ext_irq_b_trigger_type <= wr.data[`DTC_IT_B];
      end
      if (wr.en && wr.idx == `DTC_IDX_CFG) begin
        six_clock_cycle_mode <= wr.data[0];
      end
    end
  end

  // flag update: hardware set wins over software write and service clear
  function automatic logic flag_next(
    input logic cur,
    input logic hw,
    input logic sw_wr,
    input logic sw_val,
    input logic svc
  );
    flag_next = hw || (!svc && (sw_wr ? sw_val : cur));
  endfunction

  // sticky flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_a_overflow_flag <= 1'b0;
      timer_b_overflow_flag <= 1'b0;
      ext_irq_a_edge_flag   <= 1'b0;
      ext_irq_b_edge_flag   <= 1'b0;
    end else begin
      timer_a_overflow_flag <= flag_next(timer_a_overflow_flag, hw_tf_a, wr_ctrl,
        wr.data[`DTC_TF_A], wr_svc && wr.data[`DTC_SVC_TF_A]);
      timer_b_overflow_flag <= flag_next(timer_b_overflow_flag, hw_tf_b, wr_ctrl,
        wr.data[`DTC_TF_B], wr_svc && wr.data[`DTC_SVC_TF_B]);
      ext_irq_a_edge_flag   <= flag_next(ext_irq_a_edge_flag, hw_ie_a, wr_ctrl,
        wr.data[`DTC_IE_A], wr_svc && wr.data[`DTC_SVC_IE_A]);
      ext_irq_b_edge_flag   <= flag_next(ext_irq_b_edge_flag, hw_ie_b, wr_ctrl,
        wr.data[`DTC_IE_B], wr_svc && wr.data[`DTC_SVC_IE_B]);
    end
  end

  // read mux
  always_comb begin
    case (rd_idx)
      `DTC_IDX_CTRL: rd_data = {timer_b_overflow_flag, timer_b_run,
                                timer_a_overflow_flag, timer_a_run,
                                ext_irq_b_edge_flag, ext_irq_b_trigger_type,
                                ext_irq_a_edge_flag, ext_irq_a_trigger_type};
      `DTC_IDX_MODE: rd_data = timer_mode_select;
      `DTC_IDX_TL_A: rd_data = timer_a_count_low;
      `DTC_IDX_TL_B: rd_data = timer_b_count_low;
      `DTC_IDX_TH_A: rd_data = timer_a_count_high;
      `DTC_IDX_TH_B: rd_data = timer_b_count_high;
      `DTC_IDX_CFG:  rd_data = {7'h00, six_clock_cycle_mode};
      default:       rd_data = 8'h00;
    endcase
  end

  // checker helper: clocks since the last tick, and whether the cycle mode held all along
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mc_since     <= 4'h0;
      mc_mode_held <= 1'b0;
    end else begin
      mc_since     <= mc_tick ? 4'h0 : mc_since + 4'h1;
      mc_mode_held <= mc_tick || (mc_mode_held && !(wr.en && wr.idx == `DTC_IDX_CFG));
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mc_gap_twelve_a: assert property (
    (mc_tick && mc_mode_held && !six_clock_cycle_mode) |-> mc_since == 4'hB)
    else $error("machine cycle is not twelve clocks");

  mc_gap_six_a: assert property (
    (mc_tick && mc_mode_held && six_clock_cycle_mode) |-> mc_since == 4'h5)
    else $error("machine cycle is not six clocks");

  edge_on_tick_a: assert property (
    cnt_fall[0] |-> mc_tick && cnt_prev[0] && !cnt_now[0])
    else $error("count edge outside machine cycle");

  halt_no_run_a: assert property (
    (!timer_a_run && !split_a && !wr.en)
    |=> $stable({timer_a_count_high, timer_a_count_low}))
    else $error("timer a moved while halted");

  wrap_thirteen_a: assert property (
    (inc_a && cfg_a.mode == dtc_pkg::DTC_MODE_13 && !wr.en
     && timer_a_count_high == 8'hFF && timer_a_count_low[4:0] == 5'h1F)
    |=> timer_a_overflow_flag && timer_a_count_high == 8'h00
        && timer_a_count_low == 8'h00)
    else $error("13-bit wrap wrong");

  upper_zero_a: assert property (
    (inc_a && cfg_a.mode == dtc_pkg::DTC_MODE_13 && !wr.en)
    |=> timer_a_count_low[7:5] == 3'h0)
    else $error("13-bit low byte upper bits set");

  reload_eight_a: assert property (
    (inc_a && cfg_a.mode == dtc_pkg::DTC_MODE_8R && !wr.en
     && timer_a_count_low == 8'hFF)
    |=> timer_a_count_low == $past(timer_a_count_high)
        && $stable(timer_a_count_high) && timer_a_overflow_flag)
    else $error("auto-reload wrong");

  wrap_sixteen_a: assert property (
    (inc_b && cfg_b.mode == dtc_pkg::DTC_MODE_16 && !wr.en && !split_a
     && {timer_b_count_high, timer_b_count_low} == 16'hFFFF)
    |=> timer_b_overflow_flag && timer_b_count_low == 8'h00
        && timer_b_count_high == 8'h00)
    else $error("16-bit wrap wrong");

  stop_b_a: assert property (
    (cfg_b.mode == dtc_pkg::DTC_MODE_SP && !wr.en)
    |=> $stable({timer_b_count_high, timer_b_count_low}))
    else $error("timer b moved in stop mode");

  split_high_a: assert property (
    (inc_h && timer_a_count_high == 8'hFF && !wr.en) |=> timer_b_overflow_flag)
    else $error("split high byte overflow lost");

  set_wins_a: assert property (
    (hw_tf_a && wr_ctrl && !wr.data[`DTC_TF_A]) |=> timer_a_overflow_flag)
    else $error("software clear beat hardware set");

  edge_flag_a: assert property (
    (ext_irq_a_trigger_type && irq_fall[0]) |=> ext_irq_a_edge_flag)
    else $error("edge flag not set");
endmodule // dtc_timer_unit

// ---- testbench/dtc_pin_model.sv ----
// far-side model driving the count pins and external interrupt pins
`timescale 1ns/1ps
module dtc_pin_model (
  input  wire logic aclk,
  output      logic count_input_a,
  output      logic count_input_b,
  output      logic ext_irq_a_pin,
  output      logic ext_irq_b_pin
);
  // pins rest high, matching the preset synchronisers
  initial begin
    {count_input_a, count_input_b, ext_irq_a_pin, ext_irq_b_pin} = 4'hF;
  end
  // n falling edges on one count pin, each level held two machine cycles
  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (pin == 0) count_input_a <= 1'b0; else count_input_b <= 1'b0;
      repeat (24) @(posedge aclk);
      if (pin == 0) count_input_a <= 1'b1; else count_input_b <= 1'b1;
      repeat (24) @(posedge aclk);
    end
  endtask
  // set the level of one external interrupt pin
  task automatic set_irq(input int pin, input logic lvl);
    @(posedge aclk);
    if (pin == 0) ext_irq_a_pin <= lvl; else ext_irq_b_pin <= lvl;
  endtask
endmodule // dtc_pin_model

// ---- testbench/testbench.sv ----
// self-checking bench for the dual timer unit over its register bus
`timescale 1ns/1ps
module testbench;
  localparam logic [9:0] CTL = 10'h220, MOD = 10'h224, TLA = 10'h228, TLB = 10'h22C;
  localparam logic [9:0] THA = 10'h230, THB = 10'h234, CFG = 10'h238, SVC = 10'h23C;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [9:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, fa, fb, ea, eb;
  logic [1:0] bresp, rresp, resp;
  logic ca, cb, ia, ib;
  int miscompares = 0, total_checks = 0;
  dtc_timer_unit dtc_timer_unit_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_input_a(ca), .count_input_b(cb), .ext_irq_a_pin(ia), .ext_irq_b_pin(ib),
    .timer_a_overflow_flag(fa), .timer_b_overflow_flag(fb),
    .ext_irq_a_edge_flag(ea), .ext_irq_b_edge_flag(eb));
  dtc_pin_model dtc_pin_model_i (.aclk(aclk), .count_input_a(ca), .count_input_b(cb),
    .ext_irq_a_pin(ia), .ext_irq_b_pin(ib));
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // compare one value, counting every check
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus write; response code left in resp
  // handshakes are judged on settled values half a period before the edge
  task automatic w(input logic [9:0] a, input logic [7:0] d);
    int k;
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 100; k++) begin
      @(negedge aclk);
      aw_ok = awvalid && awready; w_ok = wvalid && wready; b_ok = bvalid; resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 0;
      if (w_ok) wvalid <= 0;
      if (b_ok) break;
    end
    if (k == 100) miscompares++;
    bready <= 0;
  endtask
  // bus read; data left in rd, response code in resp
  task automatic r(input logic [9:0] a);
    int k;
    logic ar_ok, r_ok;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 100; k++) begin
      @(negedge aclk);
      ar_ok = arvalid && arready; r_ok = rvalid; rd = rdata; resp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 0;
      if (r_ok) break;
    end
    if (k == 100) miscompares++;
    rready <= 0;
  endtask
  // wait boundedly for one overflow flag, then check it is set
  task automatic wait_flag(input int b);
    for (int k = 0; k < 100; k++) begin
      @(negedge aclk);
      if ((b ? fb : fa) === 1'b1) break;
    end
    chk({31'h0, b ? fb : fa}, 32'h1);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      r(CTL + 10'(4 * i)); chk(rd, 32'h0); chk({30'h0, resp}, 32'h0);
    end
    r(10'h240); chk({30'h0, resp}, 32'h2);
    w(10'h240, 8'h5A); chk({30'h0, resp}, 32'h2);
  endtask
  task automatic t_mode16();
    w(MOD, 8'h01); w(THA, 8'hFF); w(TLA, 8'hFE); w(CTL, 8'h10);
    wait_flag(0);
    w(CTL, 8'h20); r(THA); chk(rd, 32'h0);
    w(SVC, 8'h01); chk({31'h0, fa}, 32'h0);
  endtask
  task automatic t_reload();
    w(MOD, 8'h20); w(THB, 8'hF0); w(TLB, 8'hFE); w(CTL, 8'h40);
    wait_flag(1);
    w(CTL, 8'h80); r(THB); chk(rd, 32'hF0);
    r(TLB); chk(rd & 32'hF0, 32'hF0);
    w(SVC, 8'h02); chk({31'h0, fb}, 32'h0);
  endtask
  task automatic t_mode13();
    w(MOD, 8'h00); w(TLA, 8'hFF); r(TLA); chk(rd, 32'h1F);
    w(THA, 8'hFF); w(CTL, 8'h10);
    wait_flag(0);
    w(CTL, 8'h20); r(THA); chk(rd, 32'h0);
    w(SVC, 8'h01);
  endtask
  task automatic t_counter();
    w(MOD, 8'h05); w(TLA, 8'h00); w(THA, 8'h00); w(CTL, 8'h10);
    dtc_pin_model_i.pulse(0, 3); r(TLA); chk(rd, 32'h3);
    w(MOD, 8'h0D); dtc_pin_model_i.set_irq(0, 1'b0);
    dtc_pin_model_i.pulse(0, 2); r(TLA); chk(rd, 32'h3);
    chk({31'h0, ea}, 32'h1);
    dtc_pin_model_i.set_irq(0, 1'b1);
    dtc_pin_model_i.pulse(0, 1); r(TLA); chk(rd, 32'h4);
    w(CTL, 8'h00); w(SVC, 8'h04);
  endtask
  task automatic t_stop_b();
    w(MOD, 8'h30); w(TLB, 8'h05); w(CTL, 8'h40);
    repeat (60) @(posedge aclk);
    r(TLB); chk(rd, 32'h5);
    w(CTL, 8'h00);
  endtask
  task automatic t_edge();
    w(CTL, 8'h05); dtc_pin_model_i.set_irq(0, 1'b0); dtc_pin_model_i.set_irq(1, 1'b0);
    repeat (5) @(negedge aclk);
    chk({31'h0, eb}, 32'h1);
    chk({31'h0, ea}, 32'h1);
    dtc_pin_model_i.set_irq(0, 1'b1); dtc_pin_model_i.set_irq(1, 1'b1); w(SVC, 8'h0C);
    @(negedge aclk); chk({31'h0, eb}, 32'h0);
    chk({31'h0, ea}, 32'h0);
  endtask
  // six-clock machine cycles: about 124 clocks of running give 20 or 21 counts
  task automatic t_six();
    w(MOD, 8'h01); w(TLA, 8'h00); w(THA, 8'h00); w(CFG, 8'h01);
    r(CFG); chk(rd, 32'h1);
    w(CTL, 8'h10); repeat (120) @(posedge aclk); w(CTL, 8'h00);
    r(TLA); chk({31'h0, rd >= 32'd19 && rd <= 32'd22}, 32'h1);
    w(CFG, 8'h00);
  endtask
  // split mode: low byte under run a, high byte under run b setting flag b
  task automatic t_split();
    w(MOD, 8'h03); w(TLA, 8'hFE); w(THA, 8'hFF); w(CTL, 8'h50);
    wait_flag(1);
    wait_flag(0);
    w(CTL, 8'h00); w(SVC, 8'h03); chk({30'h0, fb, fa}, 32'h0);
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset(); t_mode16(); t_reload(); t_mode13(); t_counter(); t_stop_b(); t_edge();
    t_six(); t_split();
    test_done();
  end
  // watchdog against a hung handshake
  initial begin
    #200us;
    miscompares++;
    test_done();
  end
endmodule // testbench
